// >>> hdl/ppm_pkg.sv
package ppm_pkg;
  // Register location in I/O port space
  localparam logic [15:0] PPM_BUS_SELECT_ADDR = 16'h1C00;
  // Field layout of external_bus_select
  localparam int          PPM_RESERVED_BIT    = 15;
  localparam int          PPM_MODE_LSB        = 12;
  localparam int          PPM_MODE_W          = 3;
  localparam logic        PPM_RESERVED_VALUE  = 1'h0;
  localparam logic [2:0]  PPM_MODE_RESET      = 3'h0;
  // Pin and peripheral widths
  localparam int          PPM_PINS            = 21;
  localparam int          PPM_SPI_W           = 7;
  localparam int          PPM_GPIO_W          = 8;
  localparam int          PPM_SER_W           = 4;
  localparam int          PPM_LCD8_W          = 8;
  // Route mode encodings
  localparam logic [2:0]  PPM_MODE_LCD16      = 3'h0;
  localparam logic [2:0]  PPM_MODE_SPI_GPIO   = 3'h1;
  localparam logic [2:0]  PPM_MODE_LCD8_GPIO  = 3'h2;
  localparam logic [2:0]  PPM_MODE_LCD8_SPI_B = 3'h3;
  localparam logic [2:0]  PPM_MODE_LCD8_A_UA  = 3'h4;
  localparam logic [2:0]  PPM_MODE_LCD8_SPI_U = 3'h5;
  localparam logic [2:0]  PPM_MODE_SPI_AB     = 3'h6;
  localparam logic [2:0]  PPM_MODE_RESERVED   = 3'h7;
endpackage : ppm_pkg

// >>> hdl/ppm_pin_mux.sv
`timescale 1ns/1ns
// What this block does
// - Bit 15 of the select register is reserved, reads a fixed zero and ignores writes.
// - A three-bit route mode field at bits 14:12 picks what drives the 21 port pins.
// - Mode 000 puts all 21 signals of the 16-bit LCD bridge on the 21 pins.
// - Mode 001 routes 7 SPI, 6 GPIO, 4 UART and 4 first audio serial signals.
// - Mode 010 routes 8 LCD pixel data bits and 8 GPIO signals.
// - Mode 011 routes 8 LCD pixel bits, 4 SPI and 4 second audio serial signals.
// - Mode 100 routes 8 LCD pixel bits, 4 first audio serial and 4 UART signals.
// - Mode 101 routes 8 LCD pixel bits, 4 SPI and 4 UART signals.
// - Mode 110 routes 7 SPI, 4 of each audio serial instance and 6 GPIO signals.
// - A new field value takes effect on the pins in the clock cycle after the write.
// - The select register sits at I/O port address 0x1C00.
module ppm_pin_mux
  import ppm_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  reset,
  input  wire logic [15:0]           io_addr,
  input  wire logic                  io_wr,
  input  wire logic                  io_rd,
  input  wire logic [15:0]           io_wdata,
  output logic      [15:0]           io_rdata,
  output logic [PPM_MODE_W-1:0]      parallel_port_route_mode,
  input  wire logic [PPM_PINS-1:0]   lcd_out,
  input  wire logic [PPM_PINS-1:0]   lcd_oe,
  output logic      [PPM_PINS-1:0]   lcd_in,
  input  wire logic [PPM_SPI_W-1:0]  spi_out,
  input  wire logic [PPM_SPI_W-1:0]  spi_oe,
  output logic      [PPM_SPI_W-1:0]  spi_in,
  input  wire logic [PPM_GPIO_W-1:0] gpio_out,
  input  wire logic [PPM_GPIO_W-1:0] gpio_oe,
  output logic      [PPM_GPIO_W-1:0] gpio_in,
  input  wire logic [PPM_SER_W-1:0]  uart_out,
  input  wire logic [PPM_SER_W-1:0]  uart_oe,
  output logic      [PPM_SER_W-1:0]  uart_in,
  input  wire logic [PPM_SER_W-1:0]  first_audio_serial_instance_out,
  input  wire logic [PPM_SER_W-1:0]  first_audio_serial_instance_oe,
  output logic      [PPM_SER_W-1:0]  first_audio_serial_instance_in,
  input  wire logic [PPM_SER_W-1:0]  second_audio_serial_instance_out,
  input  wire logic [PPM_SER_W-1:0]  second_audio_serial_instance_oe,
  output logic      [PPM_SER_W-1:0]  second_audio_serial_instance_in,
  input  wire logic [PPM_PINS-1:0]   pin_in,
  output logic      [PPM_PINS-1:0]   pin_out,
  output logic      [PPM_PINS-1:0]   pin_oe
);

  logic [PPM_MODE_W-1:0] mode_reg, mode_next;
  logic [15:0]           rdata_reg, rdata_next;
  logic                  hit;

  // Address decode
  // port address match
  assign hit = (io_addr == PPM_BUS_SELECT_ADDR);

  // Register write and read answer
  always_comb
  begin
    mode_next  = mode_reg;
    rdata_next = 16'h0000;
    if (io_wr && hit)
      mode_next = io_wdata[PPM_MODE_LSB +: PPM_MODE_W];
    if (io_rd && hit)
    begin
      rdata_next[PPM_MODE_LSB +: PPM_MODE_W] = mode_reg;
      rdata_next[PPM_RESERVED_BIT] = PPM_RESERVED_VALUE;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      mode_reg  <= PPM_MODE_RESET;
      rdata_reg <= 16'h0000;
    end
    else
    begin
      mode_reg  <= mode_next;
      rdata_reg <= rdata_next;
    end
  end

  assign io_rdata                 = rdata_reg;
  assign parallel_port_route_mode = mode_reg;

  // Outward routing, built from the next mode so pins follow the write at once
  logic [PPM_PINS-1:0] out_next, oe_next, out_reg, oe_reg;
  logic [4:0]          pad;
  assign pad = 5'h00;

  always_comb
  begin
    out_next = '0;
    oe_next  = '0;
    case (mode_next)
      PPM_MODE_LCD16:
      begin
        out_next = lcd_out;
        oe_next  = lcd_oe;
      end
      PPM_MODE_SPI_GPIO:
      begin
        out_next = {spi_out, gpio_out[5:0], uart_out, first_audio_serial_instance_out};
        oe_next  = {spi_oe, gpio_oe[5:0], uart_oe, first_audio_serial_instance_oe};
      end
      PPM_MODE_LCD8_GPIO:
      begin
        out_next = {pad, gpio_out, lcd_out[7:0]};
        oe_next  = {pad, gpio_oe, lcd_oe[7:0]};
      end
      PPM_MODE_LCD8_SPI_B:
      begin
        out_next = {pad, second_audio_serial_instance_out, spi_out[3:0], lcd_out[7:0]};
        oe_next  = {pad, second_audio_serial_instance_oe, spi_oe[3:0], lcd_oe[7:0]};
      end
      PPM_MODE_LCD8_A_UA:
      begin
        out_next = {pad, uart_out, first_audio_serial_instance_out, lcd_out[7:0]};
        oe_next  = {pad, uart_oe, first_audio_serial_instance_oe, lcd_oe[7:0]};
      end
      PPM_MODE_LCD8_SPI_U:
      begin
        out_next = {pad, uart_out, spi_out[3:0], lcd_out[7:0]};
        oe_next  = {pad, uart_oe, spi_oe[3:0], lcd_oe[7:0]};
      end
      PPM_MODE_SPI_AB:
      begin
        out_next = {spi_out, second_audio_serial_instance_out,
                    first_audio_serial_instance_out, gpio_out[5:0]};
        oe_next  = {spi_oe, second_audio_serial_instance_oe,
                    first_audio_serial_instance_oe, gpio_oe[5:0]};
      end
      default:
        oe_next = '0;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      out_reg <= '0;
      oe_reg  <= '0;
    end
    else
    begin
      out_reg <= out_next;
      oe_reg  <= oe_next;
    end
  end

  assign pin_out = out_reg;
  assign pin_oe  = oe_reg;

  // Two-stage pin synchroniser
  logic [PPM_PINS-1:0] sync1_reg, sync2_reg;
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end
    else
    begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
    end
  end

  // Inward routing of synchronised pins
  logic [PPM_PINS-1:0]   lcd_next, lcd_reg;
  logic [PPM_SPI_W-1:0]  spi_next, spi_reg;
  logic [PPM_GPIO_W-1:0] gpio_next, gpio_reg;
  logic [PPM_SER_W-1:0]  uart_next, uart_reg, aud_a_next, aud_a_reg, aud_b_next, aud_b_reg;
  logic [PPM_PINS-1:0]   s;
  assign s = sync2_reg;

  always_comb
  begin
    lcd_next   = '0;
    spi_next   = '0;
    gpio_next  = '0;
    uart_next  = '0;
    aud_a_next = '0;
    aud_b_next = '0;
    case (mode_reg)
      PPM_MODE_LCD16:
        lcd_next = s;
      PPM_MODE_SPI_GPIO:
        {spi_next, gpio_next[5:0], uart_next, aud_a_next} = s;
      PPM_MODE_LCD8_GPIO:
        {gpio_next, lcd_next[7:0]} = s[15:0];
      PPM_MODE_LCD8_SPI_B:
        {aud_b_next, spi_next[3:0], lcd_next[7:0]} = s[15:0];
      PPM_MODE_LCD8_A_UA:
        {uart_next, aud_a_next, lcd_next[7:0]} = s[15:0];
      PPM_MODE_LCD8_SPI_U:
        {uart_next, spi_next[3:0], lcd_next[7:0]} = s[15:0];
      PPM_MODE_SPI_AB:
        {spi_next, aud_b_next, aud_a_next, gpio_next[5:0]} = s;
      default:
        lcd_next = '0;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      lcd_reg   <= '0;
      spi_reg   <= '0;
      gpio_reg  <= '0;
      uart_reg  <= '0;
      aud_a_reg <= '0;
      aud_b_reg <= '0;
    end
    else
    begin
      lcd_reg   <= lcd_next;
      spi_reg   <= spi_next;
      gpio_reg  <= gpio_next;
      uart_reg  <= uart_next;
      aud_a_reg <= aud_a_next;
      aud_b_reg <= aud_b_next;
    end
  end

  assign lcd_in                          = lcd_reg;
  assign spi_in                          = spi_reg;
  assign gpio_in                         = gpio_reg;
  assign uart_in                         = uart_reg;
  assign first_audio_serial_instance_in  = aud_a_reg;
  assign second_audio_serial_instance_in = aud_b_reg;

  // Checks
  sequence reg_write_s;
    io_wr && (io_addr == PPM_BUS_SELECT_ADDR);
  endsequence
  sequence reg_read_s;
    io_rd && (io_addr == PPM_BUS_SELECT_ADDR);
  endsequence

  a_reserved_bit_zero: assert property (@(posedge clk) disable iff (reset)
    reg_read_s |=> io_rdata == {PPM_RESERVED_VALUE, $past(mode_reg), 12'h000})
    else $error("reserved bit or mode readback wrong");
  a_write_takes_mode: assert property (@(posedge clk) disable iff (reset)
    reg_write_s |=> mode_reg == $past(io_wdata[PPM_MODE_LSB +: PPM_MODE_W]))
    else $error("mode field not stored");
  a_other_addr_ignored: assert property (@(posedge clk) disable iff (reset)
    !(io_wr && io_addr == PPM_BUS_SELECT_ADDR) |=> $stable(mode_reg))
    else $error("mode changed without a matching write");
  a_write_pins_next: assert property (@(posedge clk) disable iff (reset)
    reg_write_s ##0 (io_wdata[PPM_MODE_LSB +: PPM_MODE_W] == PPM_MODE_LCD16)
      |=> pin_out == $past(lcd_out))
    else $error("pins did not follow the write next cycle");
  a_lcd16_route: assert property (@(posedge clk) disable iff (reset)
    (mode_reg == PPM_MODE_LCD16) && !$past(reset) |-> pin_oe == $past(lcd_oe))
    else $error("mode 0 enable routing wrong");
  a_spi_gpio_route: assert property (@(posedge clk) disable iff (reset)
    (mode_reg == PPM_MODE_SPI_GPIO) && !$past(reset) |-> pin_out[20:14] == $past(spi_out)
      && pin_out[3:0] == $past(first_audio_serial_instance_out))
    else $error("mode 1 routing wrong");
  a_lcd8_gpio_route: assert property (@(posedge clk) disable iff (reset)
    (mode_reg == PPM_MODE_LCD8_GPIO) && !$past(reset) |-> pin_out[15:8] == $past(gpio_out)
      && pin_oe[20:16] == 5'h00)
    else $error("mode 2 routing wrong");
  a_lcd8_spi_b: assert property (@(posedge clk) disable iff (reset)
    (mode_reg == PPM_MODE_LCD8_SPI_B) && !$past(reset) |->
      pin_out[15:12] == $past(second_audio_serial_instance_out))
    else $error("mode 3 routing wrong");
  a_lcd8_aud_uart: assert property (@(posedge clk) disable iff (reset)
    (mode_reg == PPM_MODE_LCD8_A_UA) && !$past(reset) |-> pin_out[15:12] == $past(uart_out))
    else $error("mode 4 routing wrong");
  a_lcd8_spi_uart: assert property (@(posedge clk) disable iff (reset)
    (mode_reg == PPM_MODE_LCD8_SPI_U) && !$past(reset) |-> pin_out[11:8] == $past(spi_out[3:0]))
    else $error("mode 5 routing wrong");
  a_spi_aud_gpio: assert property (@(posedge clk) disable iff (reset)
    (mode_reg == PPM_MODE_SPI_AB) && !$past(reset) |-> pin_out[5:0] == $past(gpio_out[5:0]))
    else $error("mode 6 routing wrong");
  a_reserved_mode_off: assert property (@(posedge clk) disable iff (reset)
    (mode_reg == PPM_MODE_RESERVED) && !$past(reset) |-> pin_oe == '0 ##1 (lcd_in == '0))
    else $error("reserved mode drives pins");

endmodule : ppm_pin_mux

// >>> sim/ppm_cpu_model.sv
`timescale 1ns/1ns
// CPU side of the I/O port bus, one access at a time
module ppm_cpu_model
(
  input  wire logic        clk,
  input  wire logic [15:0] io_rdata,
  output logic      [15:0] io_addr,
  output logic             io_wr,
  output logic             io_rd,
  output logic      [15:0] io_wdata
);
  // Bus idle at time zero; data lines show a changing pattern
  initial
  begin
    io_addr  = 16'h0000;
    io_wr    = 1'b0;
    io_rd    = 1'b0;
    io_wdata = 16'hA5A5;
  end

  // Write strobe held for one sampling edge
  task automatic wr(input logic [15:0] addr, input logic [15:0] data);
    @(posedge clk);
    #1;
    io_addr  = addr;
    io_wdata = data;
    io_wr    = 1'b1;
    @(posedge clk);
    #1;
    io_wr    = 1'b0;
    io_wdata = ~data; // Released data is not left looking valid
  endtask : wr

  // Read strobe; data taken from the registered answer
  task automatic rd(input logic [15:0] addr, output logic [15:0] data);
    @(posedge clk);
    #1;
    io_addr = addr;
    io_rd   = 1'b1;
    @(posedge clk);
    #1;
    io_rd   = 1'b0;
    data    = io_rdata;
  endtask : rd
endmodule : ppm_cpu_model

// >>> sim/parallel_port_pin_mux_tb.sv
`timescale 1ns/1ns
module parallel_port_pin_mux_tb;
  import ppm_pkg::*;
  logic        clk, reset, io_wr, io_rd;
  logic [15:0] io_addr, io_wdata, io_rdata, rv;
  logic [2:0]  route_mode;
  logic [20:0] p, q, pin_in, pin_out, pin_oe, lcd_in;
  logic [6:0]  spi_in;
  logic [7:0]  gpio_in;
  logic [3:0]  uart_in, aud_a_in, aud_b_in;
  int          bad_count = 0;
  int          total_checks = 0;
  logic [47:0] inward;

  // All inward peripheral inputs side by side
  assign inward = {lcd_in, spi_in, gpio_in, uart_in, aud_a_in, aud_b_in};

  ppm_cpu_model cpu (.clk(clk), .io_rdata(io_rdata), .io_addr(io_addr), .io_wr(io_wr),
    .io_rd(io_rd), .io_wdata(io_wdata));

  ppm_pin_mux uut (.clk(clk), .reset(reset), .io_addr(io_addr), .io_wr(io_wr),
    .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .parallel_port_route_mode(route_mode), .lcd_out(p), .lcd_oe(q), .lcd_in(lcd_in),
    .spi_out(p[8:2]), .spi_oe(q[8:2]), .spi_in(spi_in),
    .gpio_out(p[20:13]), .gpio_oe(q[20:13]), .gpio_in(gpio_in),
    .uart_out(p[12:9]), .uart_oe(q[12:9]), .uart_in(uart_in),
    .first_audio_serial_instance_out(p[3:0]), .first_audio_serial_instance_oe(q[3:0]),
    .first_audio_serial_instance_in(aud_a_in),
    .second_audio_serial_instance_out(p[19:16]), .second_audio_serial_instance_oe(q[19:16]),
    .second_audio_serial_instance_in(aud_b_in),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));

  // Expected pin image for a route mode, pins 20 down to 0
  function automatic logic [20:0] pin_map(input logic [2:0] m, input logic [20:0] v);
    case (m)
      3'h0: return v;
      3'h1: return {v[8:2], v[18:13], v[12:9], v[3:0]};
      3'h2: return {5'h00, v[20:13], v[7:0]};
      3'h3: return {5'h00, v[19:16], v[5:2], v[7:0]};
      3'h4: return {5'h00, v[12:9], v[3:0], v[7:0]};
      3'h5: return {5'h00, v[12:9], v[5:2], v[7:0]};
      3'h6: return {v[8:2], v[19:16], v[3:0], v[18:13]};
      default: return 21'h000000;
    endcase
  endfunction : pin_map

  // Expected inward image {lcd, spi, gpio, uart, audio A, audio B} for a mode
  function automatic logic [47:0] in_map(input logic [2:0] m, input logic [20:0] s);
    logic [20:0] l;
    logic [6:0]  sp;
    logic [7:0]  g;
    logic [3:0]  u, a, b;
    {l, sp, g, u, a, b} = 48'h000000000000;
    case (m)
      3'h0: l = s;
      3'h1: {sp, g[5:0], u, a} = s;
      3'h2: {g, l[7:0]} = s[15:0];
      3'h3: {b, sp[3:0], l[7:0]} = s[15:0];
      3'h4: {u, a, l[7:0]} = s[15:0];
      3'h5: {u, sp[3:0], l[7:0]} = s[15:0];
      3'h6: {sp, b, a, g[5:0]} = s;
      default: l = 21'h000000;
    endcase
    return {l, sp, g, u, a, b};
  endfunction : in_map

  // Compare tasks, one per width of result
  task automatic chk16(input string n, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk16

  task automatic chk21(input string n, input logic [20:0] e, input logic [20:0] g);
    total_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk21

  task automatic chk48(input string n, input logic [47:0] e, input logic [47:0] g);
    total_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk48

  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : stop_test

  // Clock at 25 MHz
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Hang guard
  initial
  begin
    #200000;
    bad_count++;
    stop_test();
  end

  // Main sequence
  initial
  begin
    reset  = 1'b1;
    p      = 21'h15A5A5;
    q      = 21'h0F0F33;
    pin_in = 21'h0C3A96;
    repeat (6) @(posedge clk);
    #1;
    reset = 1'b0;
    cpu.rd(PPM_BUS_SELECT_ADDR, rv);
    chk16("reset value", 16'h0000, rv); // reset read
    $display("test reset done");
    // Every route mode, bit 15 and low bits written as ones
    for (int m = 0; m < 8; m++)
    begin
      p      = 21'h15A5A5 ^ {7{m[2:0]}};
      q      = ~p ^ 21'h0F0F33;
      pin_in = ~p;
      cpu.wr(PPM_BUS_SELECT_ADDR, {1'h1, m[2:0], 12'hFFF});
      // routing seen in the cycle right after the write
      chk21("pin_out", pin_map(m[2:0], p), pin_out);
      chk21("pin_oe", pin_map(m[2:0], q), pin_oe);
      chk16("route_mode", {13'h0000, m[2:0]}, {13'h0000, route_mode});
      repeat (3) @(posedge clk);
      #1;
      if (m == 0) chk21("lcd_in", pin_in, lcd_in);
      if (m == 1 || m == 6)
        chk21("spi_in", {14'h0000, pin_in[20:14]}, {14'h0000, spi_in});
      chk48("inward", in_map(m[2:0], pin_in), inward);
      cpu.rd(PPM_BUS_SELECT_ADDR, rv);
      chk16("readback", {PPM_RESERVED_VALUE, m[2:0], 12'h000}, rv);
    end
    $display("test modes done");
    // Other addresses neither store nor answer
    cpu.wr(16'h1C01, 16'h2000);
    cpu.rd(PPM_BUS_SELECT_ADDR, rv);
    chk16("kept value", 16'h7000, rv); // decode
    cpu.rd(16'h1C01, rv);
    chk16("other read", 16'h0000, rv); // decode
    $display("test decode done");
    stop_test();
  end
endmodule : parallel_port_pin_mux_tb
